// ==== core/bb_serial_ports.sv ====
// serial transmit and receive data ports with register access
//
// Our own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/100ps
module bb_serial_ports #(
	parameter int TX_BIT_CYC = 100
) (
	// clock and reset
	input wire logic MCLK,
	input wire logic RESET_N,
	// register port
	input wire logic [7:0] REG_ADDR,
	input wire logic [7:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	output logic [7:0] REG_RDATA,
	// transmit pins
	input wire logic TX_ENVELOPE,
	input wire logic TX_DATA,
	output logic TX_BIT_CLOCK,
	output logic TX_READY,
	// modulator side
	output logic TX_MOD_BIT,
	output logic TX_MOD_ACTIVE,
	// demodulator side
	input wire logic RX_DEMOD_BIT,
	input wire logic RX_DEMOD_STROBE,
	output logic IQ_SAMPLE_STROBE,
	// receive pins
	input wire logic RX_ENABLE_IN,
	output logic RX_DATA,
	output logic RX_BIT_CLOCK,
	output logic FRAME_VALID_OUT
);
	// the 12-bit tick counter and the half-bit clock need at least 4 and at most 4095
	if (TX_BIT_CYC < 4 || TX_BIT_CYC > 4095) begin : g_bad_bit_cyc
		$error("TX_BIT_CYC out of range");
	end

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic [1:0] env_sync_ff, txd_sync_ff, rxen_sync_ff;
	// first stages feed only the second stages
	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			env_sync_ff <= 2'h0;
			txd_sync_ff <= 2'h0;
			rxen_sync_ff <= 2'h0;
		end else begin
			env_sync_ff <= {env_sync_ff[0], TX_ENVELOPE};
			txd_sync_ff <= {txd_sync_ff[0], TX_DATA};
			rxen_sync_ff <= {rxen_sync_ff[0], RX_ENABLE_IN};
		end
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	logic [7:0] pol_ff, ant_ff, pre_len_ff, rxc_ff, rdata_ff;
	logic [7:0] sig_ff [0:5]; // shadow low/high bank 0, cck low/high, shadow low/high bank 1
	bb_port_pkg::hdr_fields_t txh_ff, rxh_ff;
	logic hdr_err_ff, tx_busy_ff, valid_ff;
	logic [7:0] nxt_rdata;
	logic bank;
	assign bank = ant_ff[bb_port_pkg::ANT_BANK_BIT];

	// read mux, answered one cycle after the strobe
	always_comb begin
		nxt_rdata = 8'h00;
		if (REG_RD) begin
			unique case (REG_ADDR)
				bb_port_pkg::ADDR_IO_POLARITY: nxt_rdata = pol_ff;
				bb_port_pkg::ADDR_ANTENNA_CTRL: nxt_rdata = ant_ff;
				bb_port_pkg::ADDR_PREAMBLE_LEN: nxt_rdata = pre_len_ff;
				bb_port_pkg::ADDR_SIG_SHADOW_LOW: nxt_rdata = bank ? sig_ff[4] : sig_ff[0];
				bb_port_pkg::ADDR_SIG_SHADOW_HIGH: nxt_rdata = bank ? sig_ff[5] : sig_ff[1];
				bb_port_pkg::ADDR_SIG_CCK_LOW: nxt_rdata = sig_ff[2];
				bb_port_pkg::ADDR_SIG_CCK_HIGH: nxt_rdata = sig_ff[3];
				bb_port_pkg::ADDR_TX_SIGNAL: nxt_rdata = txh_ff.signal;
				bb_port_pkg::ADDR_TX_SERVICE: nxt_rdata = txh_ff.service;
				bb_port_pkg::ADDR_TX_LEN_HIGH: nxt_rdata = txh_ff.length[15:8];
				bb_port_pkg::ADDR_TX_LEN_LOW: nxt_rdata = txh_ff.length[7:0];
				bb_port_pkg::ADDR_RX_STATUS: nxt_rdata = {5'h00, tx_busy_ff, valid_ff, hdr_err_ff};
				bb_port_pkg::ADDR_RX_SERVICE: nxt_rdata = rxh_ff.service;
				bb_port_pkg::ADDR_RX_LEN_HIGH: nxt_rdata = rxh_ff.length[15:8];
				bb_port_pkg::ADDR_RX_LEN_LOW: nxt_rdata = rxh_ff.length[7:0];
				bb_port_pkg::ADDR_RX_CTRL: nxt_rdata = rxc_ff;
				default: nxt_rdata = 8'h00; // unmapped reads as zero
			endcase
		end
	end

	// writes; the shadowed pair lands in the bank picked by antenna bit 7
	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			pol_ff <= bb_port_pkg::RST_IO_POLARITY;
			ant_ff <= bb_port_pkg::RST_ZERO;
			pre_len_ff <= bb_port_pkg::RST_PREAMBLE_LEN;
			rxc_ff <= bb_port_pkg::RST_ZERO;
			txh_ff <= '0;
			for (int i = 0; i < 6; i++) sig_ff[i] <= bb_port_pkg::RST_ZERO;
			rdata_ff <= 8'h00;
		end else begin
			rdata_ff <= nxt_rdata;
			if (REG_WR) begin
				unique case (REG_ADDR)
					bb_port_pkg::ADDR_IO_POLARITY: pol_ff <= REG_WDATA;
					bb_port_pkg::ADDR_ANTENNA_CTRL: ant_ff <= REG_WDATA;
					bb_port_pkg::ADDR_PREAMBLE_LEN: pre_len_ff <= REG_WDATA;
					bb_port_pkg::ADDR_SIG_SHADOW_LOW: sig_ff[bank ? 4 : 0] <= REG_WDATA;
					bb_port_pkg::ADDR_SIG_SHADOW_HIGH: sig_ff[bank ? 5 : 1] <= REG_WDATA;
					bb_port_pkg::ADDR_SIG_CCK_LOW: sig_ff[2] <= REG_WDATA;
					bb_port_pkg::ADDR_SIG_CCK_HIGH: sig_ff[3] <= REG_WDATA;
					bb_port_pkg::ADDR_TX_SIGNAL: txh_ff.signal <= REG_WDATA;
					bb_port_pkg::ADDR_TX_SERVICE: txh_ff.service <= REG_WDATA;
					bb_port_pkg::ADDR_TX_LEN_HIGH: txh_ff.length[15:8] <= REG_WDATA;
					bb_port_pkg::ADDR_TX_LEN_LOW: txh_ff.length[7:0] <= REG_WDATA;
					bb_port_pkg::ADDR_RX_CTRL: rxc_ff <= REG_WDATA;
					default: ;
				endcase
			end
		end
	end
	assign REG_RDATA = rdata_ff;

	// ----------------------------------------------------------------
	// transmit framer (shares nothing with the receiver)
	// ----------------------------------------------------------------
	bb_port_pkg::tx_state_t tx_st_ff, nxt_tx_st;
	logic [11:0] tx_tick_ff, nxt_tx_tick;
	logic [10:0] tx_cnt_ff, nxt_tx_cnt;
	logic [63:0] tx_sh_ff, nxt_tx_sh;
	logic tx_clk_ff, nxt_tx_clk, tx_rdy_ff, nxt_tx_rdy, mod_bit_ff, nxt_mod_bit;
	logic mod_act_ff, nxt_mod_act, tx_clk_on_ff, nxt_tx_clk_on;
	logic env_act, bit_end;
	logic [15:0] tx_crc;
	// polarity stripped from the envelope; 1 = active
	assign env_act = env_sync_ff[1] ~^ pol_ff[bb_port_pkg::POL_TX_ENV_BIT];
	assign bit_end = (tx_tick_ff == 12'(TX_BIT_CYC - 1));

	// header check word, inverted as sent
	always_comb begin
		tx_crc = bb_port_pkg::CRC_INIT;
		for (int i = 0; i < 32; i++) tx_crc = bb_port_pkg::crc_step(tx_crc, txh_ff[i]);
		tx_crc = ~tx_crc;
	end

	always_comb begin
		nxt_tx_st = tx_st_ff;
		nxt_tx_tick = bit_end ? 12'h000 : tx_tick_ff + 12'h001;
		nxt_tx_cnt = tx_cnt_ff;
		nxt_tx_sh = tx_sh_ff;
		nxt_tx_rdy = tx_rdy_ff;
		nxt_mod_bit = mod_bit_ff;
		nxt_mod_act = mod_act_ff;
		nxt_tx_clk_on = tx_clk_on_ff;
		unique case (tx_st_ff)
			bb_port_pkg::TX_IDLE: begin
				nxt_tx_tick = 12'h000;
				nxt_mod_act = 1'b0;
				// count envelope-low time; short gaps do not restart the frame
				if (!env_act && tx_cnt_ff < 11'(bb_port_pkg::RESTART_CYC))
					nxt_tx_cnt = tx_cnt_ff + 11'h001;
				if (env_act && tx_cnt_ff >= 11'(bb_port_pkg::RESTART_CYC)) begin
					nxt_tx_st = bb_port_pkg::TX_PRE;
					nxt_tx_cnt = {pre_len_ff, 3'h0};
					nxt_mod_act = 1'b1;
					nxt_mod_bit = 1'b1;
				end
			end
			bb_port_pkg::TX_PRE: if (bit_end) begin
				nxt_mod_bit = 1'b1;
				nxt_tx_cnt = tx_cnt_ff - 11'h001;
				if (tx_cnt_ff == 11'h001) begin
					nxt_tx_st = bb_port_pkg::TX_HDR;
					// first header bit leaves with the state change, so the last one
					// lines up with the first bit clock rise
					nxt_mod_bit = bb_port_pkg::SFD_WORD[0];
					nxt_tx_sh = {1'b0, tx_crc, txh_ff, bb_port_pkg::SFD_WORD[15:1]};
					nxt_tx_cnt = 11'd64;
					nxt_tx_rdy = 1'b1;
				end
			end
			bb_port_pkg::TX_HDR: if (bit_end) begin
				// the rise that ends the header takes the first payload bit
				nxt_mod_bit = (tx_cnt_ff == 11'h001) ? txd_sync_ff[1] : tx_sh_ff[0];
				nxt_tx_sh = {1'b0, tx_sh_ff[63:1]};
				nxt_tx_cnt = tx_cnt_ff - 11'h001;
				if (tx_cnt_ff == 11'h002) nxt_tx_clk_on = 1'b1;
				if (tx_cnt_ff == 11'h001) nxt_tx_st = bb_port_pkg::TX_PAY;
			end
			bb_port_pkg::TX_PAY: begin
				if (!env_act) begin
					nxt_tx_st = bb_port_pkg::TX_FLUSH;
					nxt_tx_clk_on = 1'b0;
					nxt_tx_rdy = 1'b0;
					nxt_tx_cnt = 11'(bb_port_pkg::FLUSH_CYC);
				end else if (bit_end) begin
					nxt_mod_bit = txd_sync_ff[1];
				end
			end
			bb_port_pkg::TX_FLUSH: begin
				nxt_tx_cnt = tx_cnt_ff - 11'h001;
				nxt_mod_bit = 1'b0;
				if (tx_cnt_ff == 11'h001) begin
					nxt_tx_st = bb_port_pkg::TX_IDLE;
					nxt_tx_cnt = 11'h000;
				end
			end
			default: nxt_tx_st = bb_port_pkg::TX_IDLE;
		endcase
		// rising edge at bit start, high for first half of the bit
		nxt_tx_clk = (nxt_tx_clk_on && nxt_tx_tick < 12'(TX_BIT_CYC / 2))
			^ ~pol_ff[bb_port_pkg::POL_TX_CLK_BIT];
	end

	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			tx_st_ff <= bb_port_pkg::TX_IDLE;
			tx_tick_ff <= 12'h000;
			tx_cnt_ff <= 11'h000;
			tx_sh_ff <= 64'h0;
			tx_clk_ff <= 1'b0;
			tx_clk_on_ff <= 1'b0;
			tx_rdy_ff <= 1'b0;
			mod_bit_ff <= 1'b0;
			mod_act_ff <= 1'b0;
			TX_READY <= 1'b0;
		end else begin
			tx_st_ff <= nxt_tx_st;
			tx_tick_ff <= nxt_tx_tick;
			tx_cnt_ff <= nxt_tx_cnt;
			tx_sh_ff <= nxt_tx_sh;
			tx_clk_ff <= nxt_tx_clk;
			tx_clk_on_ff <= nxt_tx_clk_on;
			tx_rdy_ff <= nxt_tx_rdy;
			mod_bit_ff <= nxt_mod_bit;
			mod_act_ff <= nxt_mod_act;
			TX_READY <= nxt_tx_rdy ^ ~pol_ff[bb_port_pkg::POL_TX_RDY_BIT];
		end
	end
	assign TX_BIT_CLOCK = tx_clk_ff;
	assign TX_MOD_BIT = mod_bit_ff;
	assign TX_MOD_ACTIVE = mod_act_ff;
	assign tx_busy_ff = mod_act_ff;

	// ----------------------------------------------------------------
	// sample strobe, 22 of every 100 clocks
	// ----------------------------------------------------------------
	logic [6:0] ph_ff, nxt_ph;
	logic samp_ff, nxt_samp;
	always_comb begin
		nxt_ph = ph_ff + 7'(bb_port_pkg::SAMPLE_MHZ);
		nxt_samp = 1'b0;
		if (nxt_ph >= 7'(bb_port_pkg::CLK_MHZ)) begin
			nxt_ph = nxt_ph - 7'(bb_port_pkg::CLK_MHZ);
			nxt_samp = rxen_sync_ff[1];
		end
	end
	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			ph_ff <= 7'h00;
			samp_ff <= 1'b0;
		end else begin
			ph_ff <= nxt_ph;
			samp_ff <= nxt_samp;
		end
	end
	assign IQ_SAMPLE_STROBE = samp_ff;

	// ----------------------------------------------------------------
	// receive deframer
	// ----------------------------------------------------------------
	bb_port_pkg::rx_state_t rx_st_ff, nxt_rx_st;
	logic [31:0] rx_sh_ff, nxt_rx_sh;
	logic [15:0] rx_crc_ff, nxt_rx_crc;
	logic [5:0] rx_cnt_ff, nxt_rx_cnt;
	logic [2:0] rck_ff, nxt_rck;
	logic rxd_ff, nxt_rxd, nxt_valid, nxt_hdr_err, sig_ok, after_crc, en;
	bb_port_pkg::hdr_fields_t nxt_rxh;
	assign en = rxen_sync_ff[1];
	assign after_crc = rxc_ff[bb_port_pkg::RXC_VALID_AFTER_CRC_BIT];
	// held signal field must match a bank 0 shadow or cck value (sig_ff[0] to [3]); the shifter moves on during crc
	assign sig_ok = (rxh_ff.signal == sig_ff[0]) || (rxh_ff.signal == sig_ff[1])
		|| (rxh_ff.signal == sig_ff[2]) || (rxh_ff.signal == sig_ff[3]);

	always_comb begin
		nxt_rx_st = rx_st_ff;
		nxt_rx_sh = rx_sh_ff;
		nxt_rx_crc = rx_crc_ff;
		nxt_rx_cnt = rx_cnt_ff;
		nxt_rxd = rxd_ff;
		nxt_valid = valid_ff;
		nxt_hdr_err = hdr_err_ff;
		nxt_rxh = rxh_ff;
		nxt_rck = (rck_ff != 3'h0) ? rck_ff - 3'h1 : 3'h0;
		if (!en) begin
			nxt_rx_st = bb_port_pkg::RX_HUNT;
			nxt_valid = 1'b0;
			nxt_rck = 3'h0;
			nxt_rx_sh = 32'h0;
		end else if (RX_DEMOD_STROBE) begin
			nxt_rx_sh = {RX_DEMOD_BIT, rx_sh_ff[31:1]}; // lsb arrives first
			unique case (rx_st_ff)
				bb_port_pkg::RX_HUNT: if (nxt_rx_sh[31:16] == bb_port_pkg::SFD_WORD) begin
					nxt_rx_st = bb_port_pkg::RX_HDR;
					nxt_rx_cnt = 6'd32;
					nxt_rx_crc = bb_port_pkg::CRC_INIT;
					nxt_hdr_err = 1'b0;
					nxt_valid = !after_crc;
				end
				bb_port_pkg::RX_HDR: begin
					nxt_rxd = RX_DEMOD_BIT;
					nxt_rck = 3'(bb_port_pkg::RX_CLK_HI_CYC);
					nxt_rx_crc = bb_port_pkg::crc_step(rx_crc_ff, RX_DEMOD_BIT);
					nxt_rx_cnt = rx_cnt_ff - 6'h01;
					if (rx_cnt_ff == 6'h01) begin
						nxt_rx_st = bb_port_pkg::RX_CRC;
						nxt_rx_cnt = 6'd16;
						nxt_rxh = nxt_rx_sh;
					end
				end
				bb_port_pkg::RX_CRC: begin // no clock here
					nxt_rx_cnt = rx_cnt_ff - 6'h01;
					if (rx_cnt_ff == 6'h01) begin
						if ((nxt_rx_sh[31:16] != ~rx_crc_ff) || !sig_ok) begin
							nxt_rx_st = bb_port_pkg::RX_HUNT;
							nxt_hdr_err = 1'b1;
							nxt_valid = 1'b0;
						end else begin
							nxt_rx_st = bb_port_pkg::RX_PAY;
							nxt_valid = 1'b1;
						end
					end
				end
				bb_port_pkg::RX_PAY: begin
					nxt_rxd = RX_DEMOD_BIT;
					nxt_rck = 3'(bb_port_pkg::RX_CLK_HI_CYC);
				end
			endcase
		end
	end

	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			rx_st_ff <= bb_port_pkg::RX_HUNT;
			rx_sh_ff <= 32'h0;
			rx_crc_ff <= bb_port_pkg::CRC_INIT;
			rx_cnt_ff <= 6'h00;
			rck_ff <= 3'h0;
			rxd_ff <= 1'b0;
			valid_ff <= 1'b0;
			hdr_err_ff <= 1'b0;
			rxh_ff <= '0;
			RX_BIT_CLOCK <= 1'b0;
			FRAME_VALID_OUT <= 1'b0;
		end else begin
			rx_st_ff <= nxt_rx_st;
			rx_sh_ff <= nxt_rx_sh;
			rx_crc_ff <= nxt_rx_crc;
			rx_cnt_ff <= nxt_rx_cnt;
			rck_ff <= nxt_rck;
			rxd_ff <= nxt_rxd;
			valid_ff <= nxt_valid;
			hdr_err_ff <= nxt_hdr_err;
			rxh_ff <= nxt_rxh;
			// clock rises one cycle after its data bit settles
			RX_BIT_CLOCK <= (rck_ff != 3'h0) ^ ~pol_ff[bb_port_pkg::POL_RX_CLK_BIT];
			FRAME_VALID_OUT <= nxt_valid ^ ~pol_ff[bb_port_pkg::POL_RX_RDY_BIT];
		end
	end
	assign RX_DATA = rxd_ff;
endmodule

// ==== common/bb_port_pkg.sv ====
// package: register map, field positions, timing and types for the serial data ports
package bb_port_pkg;
	// ----------------------------------------------------------------
	// register byte addresses
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_IO_POLARITY = 8'h04;
	localparam logic [7:0] ADDR_ANTENNA_CTRL = 8'h14;
	localparam logic [7:0] ADDR_PREAMBLE_LEN = 8'h18;
	localparam logic [7:0] ADDR_SIG_SHADOW_LOW = 8'h40;
	localparam logic [7:0] ADDR_SIG_SHADOW_HIGH = 8'h44;
	localparam logic [7:0] ADDR_SIG_CCK_LOW = 8'h48;
	localparam logic [7:0] ADDR_SIG_CCK_HIGH = 8'h4C;
	localparam logic [7:0] ADDR_TX_SIGNAL = 8'h50;
	localparam logic [7:0] ADDR_TX_SERVICE = 8'h54;
	localparam logic [7:0] ADDR_TX_LEN_HIGH = 8'h58;
	localparam logic [7:0] ADDR_TX_LEN_LOW = 8'h5C;
	localparam logic [7:0] ADDR_RX_STATUS = 8'h60;
	localparam logic [7:0] ADDR_RX_SERVICE = 8'h64;
	localparam logic [7:0] ADDR_RX_LEN_HIGH = 8'h68;
	localparam logic [7:0] ADDR_RX_LEN_LOW = 8'h6C;
	localparam logic [7:0] ADDR_RX_CTRL = 8'h7C;
	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int POL_TX_CLK_BIT = 0;
	localparam int POL_TX_ENV_BIT = 1;
	localparam int POL_TX_RDY_BIT = 2;
	localparam int POL_RX_RDY_BIT = 6;
	localparam int POL_RX_CLK_BIT = 7;
	localparam int ANT_BANK_BIT = 7;
	localparam int RXC_VALID_AFTER_CRC_BIT = 0;
	// ----------------------------------------------------------------
	// reset values and frame constants
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_IO_POLARITY = 8'hFF;
	localparam logic [7:0] RST_PREAMBLE_LEN = 8'h80;
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [15:0] SFD_WORD = 16'hF3A0;
	localparam logic [15:0] CRC_INIT = 16'hFFFF;
	localparam logic [15:0] CRC_POLY = 16'h1021;
	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_MHZ = 100;
	localparam real FLUSH_US = 2.0;
	localparam real RESTART_GAP_US = 2.22;
	localparam real MOD_RESET_GAP_US = 4.22;
	localparam int FLUSH_CYC = int'($floor(FLUSH_US * CLK_MHZ));
	localparam int RESTART_CYC = int'($ceil(RESTART_GAP_US * CLK_MHZ));
	localparam int SAMPLE_MHZ = 22;
	localparam int RX_CLK_HI_CYC = 4;
	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		TX_IDLE = 3'h0, TX_PRE = 3'h1, TX_HDR = 3'h3, TX_PAY = 3'h2, TX_FLUSH = 3'h6
	} tx_state_t;
	typedef enum logic [1:0] {
		RX_HUNT = 2'h0, RX_HDR = 2'h1, RX_CRC = 2'h3, RX_PAY = 2'h2
	} rx_state_t;
	typedef struct packed {
		logic [15:0] length;
		logic [7:0] service;
		logic [7:0] signal;
	} hdr_fields_t;

	// header check sequence over the fields, lsb of each byte first
	function automatic logic [15:0] crc_step(input logic [15:0] crc, input logic bit_in);
		logic fb;
		fb = crc[15] ^ bit_in;
		crc_step = {crc[14:0], 1'b0} ^ (fb ? CRC_POLY : 16'h0000);
	endfunction
endpackage

// ==== test/bb_serial_ports_checker.sv ====
// checker: port timing of the serial data ports
`timescale 1ns/100ps
module bb_serial_ports_checker #(
	parameter int TX_BIT_CYC = 100
) (
	// clock, reset, register writes
	input wire logic MCLK,
	input wire logic RESET_N,
	input wire logic [7:0] REG_ADDR,
	input wire logic [7:0] REG_WDATA,
	input wire logic REG_WR,
	// transmit side
	input wire logic TX_ENVELOPE,
	input wire logic TX_BIT_CLOCK,
	input wire logic TX_READY,
	input wire logic TX_MOD_ACTIVE,
	// receive side
	input wire logic RX_DEMOD_STROBE,
	input wire logic RX_ENABLE_IN,
	input wire logic RX_BIT_CLOCK,
	input wire logic FRAME_VALID_OUT,
	input wire logic IQ_SAMPLE_STROBE
);
	logic pol_alt_ff;
	logic nxt_pol_alt;
	logic [8:0] flush_ff;
	logic [8:0] nxt_flush;

	// ----------------------------------------------------------------
	// helper state
	// ----------------------------------------------------------------
	// checks assume active-high pins, so they stand down once polarity changes
	always_comb begin
		nxt_pol_alt = pol_alt_ff | (REG_WR && REG_ADDR == bb_port_pkg::ADDR_IO_POLARITY
			&& REG_WDATA != 8'hFF);
		nxt_flush = (TX_READY || !TX_MOD_ACTIVE) ? 9'h000 : flush_ff + 9'h001;
	end

	// register the helpers
	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			pol_alt_ff <= 1'b0;
			flush_ff <= 9'h000;
		end else begin
			pol_alt_ff <= nxt_pol_alt;
			flush_ff <= nxt_flush;
		end
	end

	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!RESET_N || pol_alt_ff);

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	a_tx_bit_clock_in_frame: assert property (TX_BIT_CLOCK |-> TX_MOD_ACTIVE)
		else $error("tx bit clock outside a frame");
	a_tx_bit_clock_stops: assert property ((!TX_ENVELOPE)[*8] |-> !$rose(TX_BIT_CLOCK))
		else $error("tx bit clock runs without envelope");
	a_ready_in_frame: assert property (TX_READY |-> TX_MOD_ACTIVE)
		else $error("tx ready outside a frame");
	a_flush_len: assert property ($fell(TX_MOD_ACTIVE) |->
		$past(flush_ff) inside {[9'h0C5:9'h0CB]})
		else $error("flush length wrong");
	a_rx_bit_clock_width: assert property ($rose(RX_BIT_CLOCK) |->
		RX_BIT_CLOCK[*4] ##1 !RX_BIT_CLOCK)
		else $error("rx clock pulse width wrong");
	a_rx_bit_clock_cause: assert property ($rose(RX_BIT_CLOCK) |-> $past(RX_DEMOD_STROBE, 2))
		else $error("rx clock without a demodulated bit");
	a_standby_quiet: assert property ((!RX_ENABLE_IN)[*6] |->
		!$rose(RX_BIT_CLOCK) && !IQ_SAMPLE_STROBE)
		else $error("receive activity in standby");
	a_valid_drops: assert property ((!RX_ENABLE_IN)[*5] |-> !FRAME_VALID_OUT)
		else $error("frame valid held without enable");

	// main scenarios seen
	cover property ($rose(TX_READY));
	cover property ($rose(FRAME_VALID_OUT));
	cover property ($fell(TX_MOD_ACTIVE));
endmodule

// ==== test/tx_source_model.sv ====
// far-side payload source for the transmit port
`timescale 1ns/100ps
module tx_source_model (
	// clock
	input wire logic MCLK,
	// device bit clock
	input wire logic TX_BIT_CLOCK,
	// driven pins
	output logic TX_ENVELOPE,
	output logic TX_DATA
);
	logic busy;

	initial begin
		TX_ENVELOPE = 1'b0;
		TX_DATA = 1'b0;
		busy = 1'b0;
	end

	// no pull on the data line: keep it moving so a stale value is never trusted
	always @(posedge MCLK) begin
		if (!busy) begin
			TX_DATA <= ~TX_DATA;
		end
	end

	// first rise falls in the last header bit and already takes payload bit 0; each later rise but the last takes the next bit
	task automatic send(input int n, input logic [15:0] bits);
		int i;
		int k;
		logic p;
		@(posedge MCLK);
		busy <= 1'b1;
		TX_ENVELOPE <= 1'b1;
		p = 1'b0;
		i = 0;
		for (k = 0; i <= n && k < 3000; k++) begin
			@(posedge MCLK);
			if (TX_BIT_CLOCK && !p) begin
				if (i < n) begin
					TX_DATA <= bits[i];
				end
				i++;
			end
			p = TX_BIT_CLOCK;
		end
		TX_ENVELOPE <= 1'b0;
		busy <= 1'b0;
		repeat (230) @(posedge MCLK);
	endtask
endmodule

// ==== test/bb_serial_ports_test.sv ====
// testbench for the serial data ports
`timescale 1ns/100ps
module bb_serial_ports_test;
	logic [7:0] REG_ADDR, REG_WDATA, REG_RDATA;
	logic MCLK, RESET_N, REG_WR, REG_RD, TX_ENVELOPE, TX_DATA, TX_BIT_CLOCK, TX_READY;
	logic TX_MOD_BIT, TX_MOD_ACTIVE, RX_DEMOD_BIT, RX_DEMOD_STROBE, IQ_SAMPLE_STROBE;
	logic RX_ENABLE_IN, RX_DATA, RX_BIT_CLOCK, FRAME_VALID_OUT;
	int n_fail = 0;
	int check_count = 0;
	logic [7:0] sigs [4] = '{8'h0A, 8'h14, 8'h37, 8'h6E};

	// 100 MHz clock
	always #5 MCLK = ~MCLK;

	bb_serial_ports #(.TX_BIT_CYC(8)) bb_serial_ports_inst (.MCLK(MCLK), .RESET_N(RESET_N),
		.REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
		.REG_RDATA(REG_RDATA), .TX_ENVELOPE(TX_ENVELOPE), .TX_DATA(TX_DATA),
		.TX_BIT_CLOCK(TX_BIT_CLOCK), .TX_READY(TX_READY), .TX_MOD_BIT(TX_MOD_BIT),
		.TX_MOD_ACTIVE(TX_MOD_ACTIVE), .RX_DEMOD_BIT(RX_DEMOD_BIT),
		.RX_DEMOD_STROBE(RX_DEMOD_STROBE), .IQ_SAMPLE_STROBE(IQ_SAMPLE_STROBE),
		.RX_ENABLE_IN(RX_ENABLE_IN), .RX_DATA(RX_DATA), .RX_BIT_CLOCK(RX_BIT_CLOCK),
		.FRAME_VALID_OUT(FRAME_VALID_OUT));
	tx_source_model tx_source_model_inst (.MCLK(MCLK), .TX_BIT_CLOCK(TX_BIT_CLOCK),
		.TX_ENVELOPE(TX_ENVELOPE), .TX_DATA(TX_DATA));

	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic complete_run();
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic chk_v(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk_b(input logic got, input logic exp);
		chk_v({7'h00, got}, {7'h00, exp});
	endtask
	task automatic step();
		@(posedge MCLK);
		#1;
	endtask
	// bounded wait; running out ends the run as a failure
	task automatic wait_lvl(ref logic s, input logic v, input int lim);
		int k;
		for (k = 0; k < lim && s !== v; k++) step();
		if (s !== v) begin
			chk_b(s, v);
			complete_run();
		end
	endtask
	task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge MCLK);
		REG_WR <= 1'b1;
		REG_ADDR <= a;
		REG_WDATA <= d;
		@(posedge MCLK);
		REG_WR <= 1'b0;
	endtask
	task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge MCLK);
		REG_RD <= 1'b1;
		REG_ADDR <= a;
		@(posedge MCLK);
		REG_RD <= 1'b0;
		#1;
		d = REG_RDATA;
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	// one transmit frame: preamble length, header bits, payload capture
	task automatic tx_frame();
		logic [63:0] h;
		logic [15:0] c;
		logic [11:0] d;
		logic p;
		int k;
		int r;
		h = {16'h0000, 16'h1234, 8'h04, 8'h0A, 16'hF3A0};
		c = 16'hFFFF;
		for (k = 16; k < 48; k++) c = {c[14:0], 1'b0} ^ ((c[15] ^ h[k]) ? 16'h1021 : 16'h0000);
		h[63:48] = ~c;
		d = 12'hA5C;
		fork
			tx_source_model_inst.send(12, {4'h0, d});
		join_none
		wait_lvl(TX_MOD_ACTIVE, 1'b1, 50);
		for (k = 0; k < 200 && TX_READY !== 1'b1; k++) step();
		chk_b(k >= 63 && k <= 65, 1'b1);
		for (k = 0; k < 64; k++) begin
			repeat ((k == 0) ? 3 : 8) step();
			chk_b(TX_MOD_BIT, h[k]);
		end
		chk_b(TX_BIT_CLOCK, 1'b1);
		// that rise inside the last header bit already asked for payload bit 0
		p = TX_BIT_CLOCK;
		r = 1;
		for (k = 0; k < 400 && r < 13; k++) begin
			step();
			if (TX_BIT_CLOCK && !p) begin
				if (r > 0) chk_b(TX_MOD_BIT, d[r - 1]);
				r++;
			end
			p = TX_BIT_CLOCK;
		end
		chk_v(8'(r), 8'h0D);
		wait_lvl(TX_MOD_ACTIVE, 1'b0, 400);
	endtask

	// one received frame; ok says whether the header should pass
	task automatic rx_frame(input logic [7:0] sg, input logic bad, input logic aft,
		input logic ok);
		logic [79:0] b;
		logic [15:0] c;
		logic [7:0] v;
		logic p;
		logic fv;
		int k;
		int n [3];
		b = {8'hC5, 16'h0000, 16'h0123, 8'h5A, sg, 16'hF3A0, 8'hFF};
		c = 16'hFFFF;
		for (k = 24; k < 56; k++) c = {c[14:0], 1'b0} ^ ((c[15] ^ b[k]) ? 16'h1021 : 16'h0000);
		b[71:56] = ~c ^ {15'h0000, bad};
		n = '{0, 0, 0};
		p = 1'b0;
		fv = 1'b0;
		for (k = 0; k < 640; k++) begin
			@(posedge MCLK);
			RX_DEMOD_STROBE <= (k % 8 == 0);
			RX_DEMOD_BIT <= b[k / 8] ^ (k % 8 != 0);
			#1;
			if (k == 244) fv = FRAME_VALID_OUT;
			if (RX_BIT_CLOCK && !p) begin
				n[(k / 8 < 56) ? 0 : (k / 8 < 72) ? 1 : 2]++;
				if (k / 8 < 56 || k / 8 >= 72) chk_b(RX_DATA, b[k / 8]);
			end
			p = RX_BIT_CLOCK;
		end
		chk_b(fv, !aft);
		chk_v(8'(n[0]), 8'h20);
		chk_v(8'(n[1]), 8'h00);
		chk_v(8'(n[2]), ok ? 8'h08 : 8'h00);
		chk_b(FRAME_VALID_OUT, ok);
		reg_rd(bb_port_pkg::ADDR_RX_STATUS, v);
		chk_b(v[0], !ok);
		@(posedge MCLK);
		RX_ENABLE_IN <= 1'b0;
		repeat (8) step();
		chk_b(FRAME_VALID_OUT, 1'b0);
		@(posedge MCLK);
		RX_ENABLE_IN <= 1'b1;
		repeat (8) step();
	endtask

	// sample strobe rate while enabled, silence in standby
	task automatic iq_rate();
		int k;
		int n;
		n = 0;
		for (k = 0; k < 1000; k++) begin
			step();
			if (IQ_SAMPLE_STROBE === 1'b1) n++;
		end
		chk_v(8'(n), 8'hDC);
		@(posedge MCLK);
		RX_ENABLE_IN <= 1'b0;
		repeat (5) step();
		n = 0;
		for (k = 0; k < 200; k++) begin
			step();
			if (IQ_SAMPLE_STROBE !== 1'b0) n++;
		end
		chk_v(8'(n), 8'h00);
		@(posedge MCLK);
		RX_ENABLE_IN <= 1'b1;
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		logic [7:0] v;
		int i;
		MCLK = 1'b0;
		RESET_N = 1'b0;
		{REG_ADDR, REG_WDATA, REG_WR, REG_RD} = 18'h00000;
		{RX_DEMOD_BIT, RX_DEMOD_STROBE} = 2'h0;
		RX_ENABLE_IN = 1'b1;
		repeat (6) @(posedge MCLK);
		RESET_N <= 1'b1;
		// transmit start needs a long quiet envelope first
		repeat (300) step();
		reg_rd(bb_port_pkg::ADDR_IO_POLARITY, v);
		chk_v(v, bb_port_pkg::RST_IO_POLARITY);
		reg_rd(bb_port_pkg::ADDR_PREAMBLE_LEN, v);
		chk_v(v, bb_port_pkg::RST_PREAMBLE_LEN);
		reg_wr(8'h01, 8'hAA);
		reg_rd(8'h01, v);
		chk_v(v, 8'h00);
		reg_wr(bb_port_pkg::ADDR_ANTENNA_CTRL, 8'h80);
		reg_wr(bb_port_pkg::ADDR_SIG_SHADOW_LOW, 8'h55);
		reg_wr(bb_port_pkg::ADDR_ANTENNA_CTRL, 8'h00);
		for (i = 0; i < 4; i++) reg_wr(bb_port_pkg::ADDR_SIG_SHADOW_LOW + 8'(4 * i), sigs[i]);
		reg_rd(bb_port_pkg::ADDR_SIG_SHADOW_LOW, v);
		chk_v(v, 8'h0A);
		reg_wr(bb_port_pkg::ADDR_ANTENNA_CTRL, 8'h80);
		reg_rd(bb_port_pkg::ADDR_SIG_SHADOW_LOW, v);
		chk_v(v, 8'h55);
		reg_wr(bb_port_pkg::ADDR_ANTENNA_CTRL, 8'h00);
		reg_wr(bb_port_pkg::ADDR_TX_SIGNAL, 8'h0A);
		reg_wr(bb_port_pkg::ADDR_TX_SERVICE, 8'h04);
		reg_wr(bb_port_pkg::ADDR_TX_LEN_HIGH, 8'h12);
		reg_wr(bb_port_pkg::ADDR_TX_LEN_LOW, 8'h34);
		reg_wr(bb_port_pkg::ADDR_PREAMBLE_LEN, 8'h01);
		// both directions at once
		fork
			tx_frame();
			rx_frame(sigs[0], 1'b0, 1'b0, 1'b1);
		join
		for (i = 1; i < 4; i++) rx_frame(sigs[i], 1'b0, 1'b0, 1'b1);
		reg_wr(bb_port_pkg::ADDR_RX_CTRL, 8'h01);
		rx_frame(8'h0A, 1'b1, 1'b1, 1'b0);
		reg_wr(bb_port_pkg::ADDR_RX_CTRL, 8'h00);
		rx_frame(8'h99, 1'b0, 1'b0, 1'b0);
		iq_rate();
		reg_wr(bb_port_pkg::ADDR_IO_POLARITY, 8'h3A);
		repeat (3) step();
		chk_b(TX_BIT_CLOCK, 1'b1);
		chk_b(TX_READY, 1'b1);
		chk_b(RX_BIT_CLOCK, 1'b1);
		chk_b(FRAME_VALID_OUT, 1'b1);
		complete_run();
	end
endmodule

bind bb_serial_ports bb_serial_ports_checker #(.TX_BIT_CYC(TX_BIT_CYC))
	bb_serial_ports_checker_inst (.MCLK(MCLK), .RESET_N(RESET_N), .REG_ADDR(REG_ADDR),
	.REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .TX_ENVELOPE(TX_ENVELOPE),
	.TX_BIT_CLOCK(TX_BIT_CLOCK), .TX_READY(TX_READY), .TX_MOD_ACTIVE(TX_MOD_ACTIVE),
	.RX_DEMOD_STROBE(RX_DEMOD_STROBE), .RX_ENABLE_IN(RX_ENABLE_IN),
	.RX_BIT_CLOCK(RX_BIT_CLOCK), .FRAME_VALID_OUT(FRAME_VALID_OUT),
	.IQ_SAMPLE_STROBE(IQ_SAMPLE_STROBE));
